// ===== hdl/fa_top.sv
// fault alarm output functions with apb configuration
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
module fa_top
  import fa_pkg::*;
#(
  parameter int TICK_CYCLES = FA_TICK_CYCLES,
  parameter int CLEAR_CYCLES = FA_CLEAR_CYCLES,
  parameter int CW = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hv_permit_input,
  input wire logic fault_clear_input,
  input wire logic cover_open_pin,
  input wire logic malfunction_in,
  input wire logic panel_reset,
  input wire logic fault_any,
  input wire logic fault_pinhole,
  input wire logic fault_metal,
  input wire logic fault_multi,
  input wire logic fault_gross,
  input wire logic [FA_V_W-1:0] actual_kv,
  input wire logic [FA_V_W-1:0] electrode_kv,
  input wire logic [FA_V_W-1:0] setpoint_kv,
  output logic [3:0] out_pins,
  output logic hv_enable
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [4*FA_SEL_W-1:0] outsel_reg;
  logic [13:0] modes_reg;
  logic [31:0] lamp_reg_cfg;
  logic [31:0] window_cfg_reg;
  logic [15:0] pct_reg;
  logic comb_reg;
  logic [FA_TIME_W-1:0] time_reg [FA_NUM_TIMERS];
  logic [CW-1:0] limit_reg [FA_NUM_COUNTS];
  logic [CW-1:0] count_reg [FA_NUM_COUNTS];
  logic panel_clr_reg;
  logic cnt_clr_reg;
  logic wr_en;
  logic [31:0] rd_next;
  logic err_next;
  logic [5:0] widx;
  logic permit_lvl;
  logic clear_lvl;
  logic cover_lvl;
  logic [FA_NUM_TIMERS-1:0] act_q;
  logic rv_reg;

  assign wr_en = ce && psel && penable && pready && pwrite && !pslverr;
  assign widx = paddr[7:2];

  always_comb begin
    rd_next = '0;
    err_next = 1'b0;
    if (paddr[1:0] != 2'h0) begin
      err_next = 1'b1;
    end else if (paddr >= FA_A_TIME0 && paddr < FA_A_LIMIT0) begin
      rd_next[FA_TIME_W-1:0] = time_reg[3'(widx - FA_A_TIME0[7:2])];
    end else if (paddr >= FA_A_LIMIT0 && paddr < FA_A_STATUS) begin
      rd_next[CW-1:0] = limit_reg[3'(widx - FA_A_LIMIT0[7:2])];
    end else begin
      unique case (paddr)
        FA_A_OUTSEL: rd_next[4*FA_SEL_W-1:0] = outsel_reg;
        FA_A_MODES: rd_next[13:0] = modes_reg;
        FA_A_LAMP: rd_next = lamp_reg_cfg;
        FA_A_WINDOW: rd_next = window_cfg_reg;
        FA_A_PCT: rd_next[15:0] = pct_reg;
        FA_A_CTRL: rd_next[FA_CTRL_COMB] = comb_reg;
        // the pulse slot does not fit the status half word
        FA_A_STATUS: rd_next[15:0] = {act_q[6:0], rv_reg, hv_enable, out_pins,
                                      permit_lvl, clear_lvl, cover_lvl};
        default: err_next = 1'b1;
      endcase
    end
  end

  // two-cycle access: pready rises one edge into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (ce) begin
      if (psel && penable && !pready) begin
        pready <= 1'b1;
        prdata <= rd_next;
        pslverr <= err_next;
      end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      outsel_reg <= '0;
      modes_reg <= '0;
      lamp_reg_cfg <= '0;
      window_cfg_reg <= '0;
      pct_reg <= '0;
      comb_reg <= 1'b0;
      panel_clr_reg <= 1'b0;
      cnt_clr_reg <= 1'b0;
      for (int i = 0; i < FA_NUM_TIMERS; i++) begin
        time_reg[i] <= FA_TIME_RST;
      end
      for (int i = 0; i < FA_NUM_COUNTS; i++) begin
        limit_reg[i] <= CW'(FA_LIMIT_RST);
      end
    end else if (ce) begin
      panel_clr_reg <= wr_en && paddr == FA_A_CTRL && pwdata[FA_CTRL_PANEL];
      cnt_clr_reg <= wr_en && paddr == FA_A_CTRL && pwdata[FA_CTRL_CNTCLR];
      if (wr_en) begin
        if (paddr >= FA_A_TIME0 && paddr < FA_A_LIMIT0) begin
          time_reg[3'(widx - FA_A_TIME0[7:2])] <= pwdata[FA_TIME_W-1:0];
        end else if (paddr >= FA_A_LIMIT0 && paddr < FA_A_STATUS) begin
          limit_reg[3'(widx - FA_A_LIMIT0[7:2])] <= pwdata[CW-1:0];
        end
        unique case (paddr)
          FA_A_OUTSEL: outsel_reg <= pwdata[4*FA_SEL_W-1:0];
          FA_A_MODES: modes_reg <= pwdata[13:0];
          FA_A_LAMP: lamp_reg_cfg <= pwdata;
          FA_A_WINDOW: window_cfg_reg <= pwdata;
          FA_A_PCT: pct_reg <= pwdata[15:0];
          FA_A_CTRL: comb_reg <= pwdata[FA_CTRL_COMB];
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // contact inputs
  // ----------------------------------------------------------------
  logic [2:0] permit_sync;
  logic [2:0] clear_sync;
  logic [2:0] cover_sync;
  logic [31:0] held_reg;
  logic pin_clr_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      permit_sync <= '0;
      clear_sync <= '0;
      cover_sync <= 3'h7;
      permit_lvl <= 1'b0;
      clear_lvl <= 1'b0;
      cover_lvl <= 1'b1;
    end else if (ce) begin
      permit_sync <= {permit_sync[1:0], hv_permit_input};
      clear_sync <= {clear_sync[1:0], fault_clear_input};
      cover_sync <= {cover_sync[1:0], cover_open_pin};
      // a level moves only once the second and third stages agree
      if (permit_sync[1] == permit_sync[2]) permit_lvl <= permit_sync[2];
      if (clear_sync[1] == clear_sync[2]) clear_lvl <= clear_sync[2];
      if (cover_sync[1] == cover_sync[2]) cover_lvl <= cover_sync[2];
    end
  end

  // one clear per closure, once it has stayed closed past the minimum
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_reg <= '0;
      pin_clr_reg <= 1'b0;
    end else if (ce) begin
      pin_clr_reg <= clear_lvl && held_reg == 32'(CLEAR_CYCLES);
      if (!clear_lvl) begin
        held_reg <= '0;
      end else if (held_reg <= 32'(CLEAR_CYCLES)) begin
        held_reg <= held_reg + 32'h0000_0001;
      end
    end
  end

  logic remote_clr;
  assign remote_clr = pin_clr_reg || panel_clr_reg || panel_reset;

  // ----------------------------------------------------------------
  // tick, counts and alarms
  // ----------------------------------------------------------------
  logic [31:0] tick_cnt_reg;
  logic tick;
  logic [FA_NUM_COUNTS-1:0] strobes;
  logic [FA_NUM_TIMERS-1:0] trig;
  logic [2*FA_NUM_TIMERS-1:0] modes_ext;

  // pulse slot has no mode field, so it reads as timed
  assign modes_ext = {2'h0, modes_reg};
  assign tick = tick_cnt_reg == 32'(TICK_CYCLES - 1);
  assign strobes = {fault_gross, fault_multi, fault_metal, fault_pinhole, fault_any};
  // typed alarms see only their own types
  assign trig = {fault_any, fault_pinhole || fault_multi, fault_metal || fault_gross,
                 fault_gross, fault_multi, fault_metal, fault_pinhole, fault_any};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= '0;
    end else if (ce) begin
      tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 32'h0000_0001;
    end
  end

  // counts saturate rather than wrap so a limit stays reached
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < FA_NUM_COUNTS; i++) count_reg[i] <= '0;
    end else if (ce) begin
      for (int i = 0; i < FA_NUM_COUNTS; i++) begin
        if (strobes[i] && count_reg[i] != '1) begin
          count_reg[i] <= count_reg[i] + CW'(1);
        end else if (cnt_clr_reg) begin
          count_reg[i] <= '0;
        end
      end
    end
  end

  for (genvar g = 0; g < FA_NUM_TIMERS; g++) begin : g_alarm
    fa_alarm #(.TW(FA_TIME_W)) u_alarm (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .tick(tick),
      .trig(trig[g]),
      .latch_mode(modes_ext[2*g+:2] != FA_MODE_TIMED),
      .hold_time(time_reg[g]),
      .clear(remote_clr),
      .active(act_q[g])
    );
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rv_reg <= 1'b0;
    end else if (ce) begin
      if (fault_any && modes_reg[2*FA_T_GEN+:2] == FA_MODE_RVF) begin
        rv_reg <= 1'b1;
      end else if (remote_clr) begin
        rv_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // voltage monitors
  // ----------------------------------------------------------------
  logic lamp_q;
  logic win_q;
  logic el_q;
  logic act_pct_q;

  function automatic logic in_band(input logic [15:0] v, input logic [15:0] sp,
                                   input logic [7:0] pct);
    logic [15:0] d;
    d = v > sp ? v - sp : sp - v;
    return 24'(d) * FA_PCT_SCALE <= 24'(sp) * 24'(pct);
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lamp_q <= 1'b0;
      win_q <= 1'b0;
      el_q <= 1'b0;
      act_pct_q <= 1'b0;
    end else if (ce) begin
      if (actual_kv >= lamp_reg_cfg[15:0]) begin
        lamp_q <= 1'b1;
      end else if (actual_kv <= lamp_reg_cfg[31:16]) begin
        lamp_q <= 1'b0;
      end
      win_q <= actual_kv >= window_cfg_reg[15:0] && actual_kv <= window_cfg_reg[31:16];
      el_q <= in_band(electrode_kv, setpoint_kv, pct_reg[7:0]);
      act_pct_q <= in_band(actual_kv, setpoint_kv, pct_reg[15:8]);
    end
  end

  // ----------------------------------------------------------------
  // output selection
  // ----------------------------------------------------------------
  logic [FA_NUM_COUNTS-1:0] at_lim;
  logic comb_hit;

  always_comb begin
    for (int i = 0; i < FA_NUM_COUNTS; i++) begin
      at_lim[i] = count_reg[i] >= limit_reg[i];
    end
  end
  assign comb_hit = comb_reg ? (at_lim[2] || at_lim[4]) : (at_lim[1] || at_lim[3]);

  function automatic logic pick(input fa_func_t f, input logic [7:0] a,
                                input logic [4:0] lim, input logic [6:0] mon);
    logic r;
    r = 1'b0;
    unique case (f)
      FA_FN_OFF: r = 1'b0;
      FA_FN_COVER: r = mon[0];
      FA_FN_MALF: r = mon[1];
      FA_FN_LAMP: r = mon[2];
      FA_FN_WINDOW: r = mon[3];
      FA_FN_EL_PCT: r = mon[4];
      FA_FN_ACT_PCT: r = mon[5];
      FA_FN_PULSE: r = a[FA_T_PULSE];
      FA_FN_GEN_AL: r = a[0];
      FA_FN_PH_AL: r = a[1];
      FA_FN_MC_AL: r = a[2];
      FA_FN_MP_AL: r = a[3];
      FA_FN_GB_AL: r = a[4];
      FA_FN_GEN_LIM: r = lim[0];
      FA_FN_PH_LIM: r = lim[1];
      FA_FN_MC_LIM: r = lim[2];
      FA_FN_MP_LIM: r = lim[3];
      FA_FN_GB_LIM: r = lim[4];
      FA_FN_COMB_LIM: r = mon[6];
      FA_FN_BW_AL: r = a[5];
      FA_FN_HOLE_AL: r = a[6];
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  logic [6:0] mon;
  assign mon = {comb_hit, act_pct_q, el_q, win_q, lamp_q, malfunction_in, cover_lvl};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_pins <= '0;
      hv_enable <= 1'b0;
    end else if (ce) begin
      for (int i = 0; i < 4; i++) begin
        out_pins[i] <= pick(fa_func_t'(outsel_reg[FA_SEL_W*i+:FA_SEL_W]), act_q, at_lim,
                            mon);
      end
      hv_enable <= permit_lvl && !cover_lvl && !rv_reg;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_OFF_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && outsel_reg[FA_SEL_W-1:0] == FA_FN_OFF) |=> !out_pins[0])
    else $error("disabled output moved");
  AST_HV_PERMIT: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && (!permit_lvl || cover_lvl)) |=> !hv_enable)
    else $error("high voltage without permit");
  AST_RVF_CUTS: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && rv_reg) |=> !hv_enable) else $error("voltage kept after fault");
  AST_LAMP_ON: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && actual_kv >= lamp_reg_cfg[15:0]) |=> lamp_q) else $error("lamp not on");
  AST_LAMP_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && actual_kv < lamp_reg_cfg[15:0] && actual_kv > lamp_reg_cfg[31:16])
    |=> lamp_q == $past(lamp_q)) else $error("lamp moved in band");
  AST_LIMIT_OUT: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && outsel_reg[FA_SEL_W-1:0] == FA_FN_GEN_LIM && at_lim[0]) |=> out_pins[0])
    else $error("limit output missing");
  AST_PIN_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && pin_clr_reg) |-> $past(clear_lvl, 2)) else $error("clear without hold");
  AST_RV_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && remote_clr && !fault_any) |=> !rv_reg)
    else $error("voltage removal survived reset");
endmodule

// ===== include/fa_pkg.sv
// constants, register map and function codes for the fault alarm output block
package fa_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int FA_CLK_MHZ = 200;
  localparam int FA_TICK_US = 10000;
  localparam int FA_CLEAR_MIN_US = 50000;
  localparam int FA_TICK_CYCLES = FA_TICK_US * FA_CLK_MHZ;
  localparam int FA_CLEAR_CYCLES = FA_CLEAR_MIN_US * FA_CLK_MHZ;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] FA_A_OUTSEL = 8'h00;
  localparam logic [7:0] FA_A_MODES = 8'h04;
  localparam logic [7:0] FA_A_LAMP = 8'h08;
  localparam logic [7:0] FA_A_WINDOW = 8'h0C;
  localparam logic [7:0] FA_A_PCT = 8'h10;
  localparam logic [7:0] FA_A_CTRL = 8'h14;
  localparam logic [7:0] FA_A_TIME0 = 8'h18;
  localparam logic [7:0] FA_A_LIMIT0 = 8'h38;
  localparam logic [7:0] FA_A_STATUS = 8'h4C;
  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int FA_SEL_W = 5;
  localparam int FA_TIME_W = 9;
  localparam int FA_V_W = 16;
  localparam int FA_NUM_TIMERS = 8;
  localparam int FA_NUM_COUNTS = 5;
  localparam int FA_CTRL_PANEL = 0;
  localparam int FA_CTRL_CNTCLR = 1;
  localparam int FA_CTRL_COMB = 2;
  localparam logic [8:0] FA_TIME_RST = 9'h00A;
  localparam logic [15:0] FA_LIMIT_RST = 16'h0001;
  localparam logic [23:0] FA_PCT_SCALE = 24'h00_0064;
  // alarm modes, two bits per timer in the mode register, none for the pulse slot
  localparam logic [1:0] FA_MODE_TIMED = 2'h0;
  localparam logic [1:0] FA_MODE_LATCH = 2'h1;
  localparam logic [1:0] FA_MODE_RVF = 2'h2;
  // timer slots: general, pinhole, metal, multi, gross, bare any, hole any, pulse
  localparam int FA_T_GEN = 0;
  localparam int FA_T_PULSE = 7;
  typedef enum logic [4:0] {
    FA_FN_OFF, FA_FN_COVER, FA_FN_MALF, FA_FN_LAMP, FA_FN_WINDOW,
    FA_FN_EL_PCT, FA_FN_ACT_PCT, FA_FN_PULSE, FA_FN_GEN_AL, FA_FN_PH_AL,
    FA_FN_MC_AL, FA_FN_MP_AL, FA_FN_GB_AL, FA_FN_GEN_LIM, FA_FN_PH_LIM,
    FA_FN_MC_LIM, FA_FN_MP_LIM, FA_FN_GB_LIM, FA_FN_COMB_LIM, FA_FN_BW_AL,
    FA_FN_HOLE_AL
  } fa_func_t;
endpackage

// ===== hdl/fa_alarm.sv
// one fault alarm: timed hold or latch, cleared by a remote reset
`timescale 1ns/1ps
module fa_alarm
  import fa_pkg::*;
#(
  parameter int TW = FA_TIME_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic tick,
  input wire logic trig,
  input wire logic latch_mode,
  input wire logic [TW-1:0] hold_time,
  input wire logic clear,
  output logic active
);
  logic [TW-1:0] left_reg;

  // ----------------------------------------------------------------
  // hold and latch
  // ----------------------------------------------------------------
  // a fault in the clear cycle wins, so no event is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active <= 1'b0;
      left_reg <= '0;
    end else if (ce) begin
      if (trig) begin
        active <= 1'b1;
        left_reg <= hold_time;
      end else if (clear) begin
        active <= 1'b0;
      end else if (active && !latch_mode && tick) begin
        // timed mode counts 10 ms ticks; first tick may come early
        if (left_reg <= TW'(1)) begin
          active <= 1'b0;
        end
        left_reg <= left_reg - TW'(1);
      end
    end
  end

  AST_TRIG_SETS: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && trig) |=> active) else $error("alarm not set by fault");
  AST_LATCH_HOLDS: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && active && latch_mode && !clear) |=> active)
    else $error("latched alarm dropped");
  AST_CLEAR_DROPS: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && clear && !trig) |=> !active)
    else $error("alarm survived clear");
endmodule

// ===== testbench/fa_field.sv
// contact switch model on the far side of the fault alarm block
`timescale 1ns/1ps
module fa_field (
  input wire logic pclk,
  input wire logic permit_req,
  input wire logic cover_req,
  input wire logic clear_go,
  input wire logic [7:0] clear_len,
  output logic hv_permit_input = 1'b0,
  output logic cover_open_pin = 1'b1,
  output logic fault_clear_input
);
  // ----
  // contacts
  // ----
  logic [7:0] left_reg = 8'h00;
  // an open permit contact is the safe default: voltage stays off
  always @(posedge pclk) hv_permit_input <= permit_req;
  always @(posedge pclk) cover_open_pin <= cover_req;
  // momentary switch: closed for clear_len cycles, then open again
  always @(posedge pclk) begin
    if (clear_go) begin
      left_reg <= clear_len;
    end else if (left_reg != 8'h00) begin
      left_reg <= left_reg - 8'h01;
    end
  end
  assign fault_clear_input = (left_reg != 8'h00);
endmodule

// ===== testbench/tb.sv
// self-checking testbench for the fault alarm output block
`timescale 1ns/1ps
module tb;
  import fa_pkg::*;
  // ----
  // signals
  // ----
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd_data;
  logic pready, pslverr, hv_enable, rd_err;
  logic malfunction_in = 1'b0, panel_reset = 1'b0, ce = 1'b1;
  logic [4:0] flt = 5'h00;
  logic [15:0] actual_kv = 16'h0000, electrode_kv = 16'h0000, setpoint_kv = 16'h03E8;
  logic [3:0] out_pins;
  logic permit_req = 1'b0, cover_req = 1'b1, clear_go = 1'b0;
  logic [7:0] clear_len = 8'h00;
  logic hv_permit_input, cover_open_pin, fault_clear_input;
  logic [15:0] va [6] = '{16'h0258, 16'h03B6, 16'h0190, 16'h012C, 16'h00F9, 16'h0190};
  logic [15:0] ve [6] = '{16'h044C, 16'h044D, 16'h0384, 16'h0383, 16'h0383, 16'h03E8};
  logic [3:0] vx [6] = '{4'h7, 4'hB, 4'h7, 4'h2, 4'h0, 4'h6};
  logic [4:0] tc [6] = '{5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h13, 5'h14};
  logic [3:0] tx [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hA, 4'h5};
  int mismatches = 0;
  int n_checks = 0;
  always #2.5 pclk = ~pclk;
  // short tick and clear counts keep the run brief
  fa_top #(.TICK_CYCLES(4), .CLEAR_CYCLES(20)) u_fa_top (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hv_permit_input(hv_permit_input), .fault_clear_input(fault_clear_input),
    .cover_open_pin(cover_open_pin), .malfunction_in(malfunction_in),
    .panel_reset(panel_reset), .fault_any(flt[0]), .fault_pinhole(flt[1]),
    .fault_metal(flt[2]), .fault_multi(flt[3]), .fault_gross(flt[4]),
    .actual_kv(actual_kv), .electrode_kv(electrode_kv), .setpoint_kv(setpoint_kv),
    .out_pins(out_pins), .hv_enable(hv_enable));
  fa_field u_fa_field (.pclk(pclk), .permit_req(permit_req), .cover_req(cover_req),
    .clear_go(clear_go), .clear_len(clear_len), .hv_permit_input(hv_permit_input),
    .cover_open_pin(cover_open_pin), .fault_clear_input(fault_clear_input));
  // ----
  // tasks
  // ----
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic pk(input logic [3:0] exp);
    chk("out_pins", 32'(exp), 32'(out_pins));
  endtask
  task automatic hv(input logic exp);
    chk("hv_enable", 32'(exp), 32'(hv_enable));
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic strobe(input logic [4:0] m);
    @(posedge pclk);
    flt <= m;
    @(posedge pclk);
    flt <= 5'h00;
    cyc(4);
  endtask
  task automatic clr(input logic [7:0] n);
    @(posedge pclk);
    clear_len <= n;
    clear_go <= 1'b1;
    @(posedge pclk);
    clear_go <= 1'b0;
  endtask
  task automatic finish_test;
    if (mismatches == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ----
  // tests
  // ----
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    cyc(1);
    pk(4'h0);
    hv(1'b0);
    apb(1'b0, FA_A_TIME0, 32'h0000_0000);
    chk("time0", 32'h0000_000A, rd_data);
    apb(1'b0, FA_A_LIMIT0, 32'h0000_0000);
    chk("limit0", 32'h0000_0001, rd_data);
    apb(1'b0, 8'h60, 32'h0000_0000);
    chk("unmapped", 32'h0000_0001, 32'(rd_err));
    apb(1'b1, FA_A_OUTSEL, 32'h0004_0041);
    apb(1'b0, FA_A_OUTSEL, 32'h0000_0000);
    chk("outsel", 32'h0004_0041, rd_data);
    cyc(8);
    pk(4'h1);
    @(posedge pclk);
    permit_req <= 1'b1;
    cyc(10);
    hv(1'b0);
    @(posedge pclk);
    cover_req <= 1'b0;
    cyc(10);
    pk(4'h0);
    hv(1'b1);
    @(posedge pclk);
    permit_req <= 1'b0;
    cyc(10);
    hv(1'b0);
    @(posedge pclk);
    permit_req <= 1'b1;
    malfunction_in <= 1'b1;
    cyc(10);
    pk(4'h2);
    // a frozen block must hold its outputs while the enable is low
    @(posedge pclk);
    ce <= 1'b0;
    malfunction_in <= 1'b0;
    cyc(6);
    pk(4'h2);
    @(posedge pclk);
    ce <= 1'b1;
    cyc(4);
    pk(4'h0);
    // off sits 2 kV under on, window spans 7 kV
    apb(1'b1, FA_A_OUTSEL, 32'h0003_1483);
    apb(1'b1, FA_A_LAMP, 32'h012C_01F4);
    apb(1'b1, FA_A_WINDOW, 32'h03B6_00FA);
    apb(1'b1, FA_A_PCT, 32'h0000_0A0A);
    for (int i = 0; i < 6; i++) begin
      @(posedge pclk);
      actual_kv <= va[i];
      electrode_kv <= ve[i];
      cyc(6);
      pk(vx[i]);
    end
    apb(1'b1, FA_A_OUTSEL, 32'h0004_0007);
    apb(1'b1, FA_A_MODES, 32'h0000_0000);
    apb(1'b1, FA_A_TIME0, 32'h0000_0003);
    apb(1'b1, FA_A_TIME0 + 8'h1C, 32'h0000_0002);
    strobe(5'h01);
    pk(4'h9);
    cyc(20);
    pk(4'h0);
    apb(1'b1, FA_A_OUTSEL, 32'h0004_0000);
    apb(1'b1, FA_A_MODES, 32'h0000_0002);
    strobe(5'h01);
    cyc(50);
    pk(4'h8);
    hv(1'b0);
    clr(8'h0A);
    cyc(40);
    pk(4'h8);
    clr(8'h28);
    cyc(60);
    pk(4'h0);
    hv(1'b1);
    apb(1'b1, FA_A_MODES, 32'h0000_1555);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, FA_A_OUTSEL, 32'(tc[i]) << 15);
      for (int t = 0; t < 4; t++) begin
        strobe(5'h02 << t);
        cyc(50);
        chk("typed alarm", 32'(tx[i][t]), 32'(out_pins[3]));
        @(posedge pclk);
        panel_reset <= 1'b1;
        @(posedge pclk);
        panel_reset <= 1'b0;
        cyc(3);
        pk(4'h0);
      end
    end
    apb(1'b1, FA_A_OUTSEL, 32'h0007_C9CD);
    apb(1'b1, FA_A_LIMIT0, 32'h0000_0002);
    apb(1'b1, FA_A_LIMIT0 + 8'h04, 32'h0000_0002);
    apb(1'b1, FA_A_CTRL, 32'h0000_0002);
    strobe(5'h03);
    pk(4'h0);
    strobe(5'h03);
    pk(4'h7);
    apb(1'b1, FA_A_CTRL, 32'h0000_0004);
    cyc(4);
    pk(4'h3);
    strobe(5'h10);
    pk(4'h7);
    strobe(5'h04);
    pk(4'hF);
    apb(1'b0, FA_A_STATUS, 32'h0000_0000);
    chk("status", 32'h0000_EEFC, rd_data);
    finish_test();
  end
  // the whole sequence needs a few thousand cycles
  initial begin
    repeat (10000) @(posedge pclk);
    mismatches++;
    finish_test();
  end
endmodule
